//--- verilog/uis_pkg.sv
// package of register map, field positions and codes for usb interrupt status
package uis_pkg;
   // ===================================================================
   // register offsets (byte addresses on the wishbone bus)
   localparam logic [7:0] MAIN_STATUS_OFS  = 8'h60; // main status word
   localparam logic [7:0] READY_STATUS_OFS = 8'h64; // pipe_ready_status
   localparam logic [7:0] ENABLE_OFS       = 8'h6C; // cause enables
   localparam logic [7:0] RESP_SEL_OFS     = 8'h70; // ctrl pipe response
   localparam logic [7:0] CLK_CTRL_OFS     = 8'h74; // internal clock enable
   // ===================================================================
   // main status field positions
   localparam int BIT_BUS_POWER_CHG = 15;
   localparam int BIT_DEV_STATE_CHG = 12;
   localparam int BIT_CTRL_STAGE_CHG = 11;
   localparam int BIT_EMPTY_SUM     = 10;
   localparam int BIT_NOT_READY_SUM = 9;
   localparam int BIT_READY_SUM     = 8;
   localparam int BIT_POWER_LEVEL   = 7;
   localparam int POS_DEV_STATE     = 4;
   localparam int BIT_SETUP_RCVD    = 3;
   localparam int POS_CTRL_STAGE    = 0;
   // ===================================================================
   // enable register field positions
   localparam int EN_BUS_RESET  = 0;
   localparam int EN_SET_ADDR   = 1;
   localparam int EN_SET_CONFIG = 2;
   localparam int EN_SUSPEND    = 3;
   localparam int EN_WR_STATUS  = 4;
   localparam int EN_RD_STATUS  = 5;
   localparam int EN_CTRL_DONE  = 6;
   localparam int EN_SEQ_ERROR  = 7;
   // ===================================================================
   // reset values
   localparam logic [15:0] READY_RESET  = 16'h0000;
   localparam logic [7:0]  ENABLE_RESET = 8'hFF;
   localparam logic [1:0]  RESP_RESET   = 2'h0;
   // ===================================================================
   // device states
   typedef enum logic [2:0] {
      UIS_POWERED    = 3'b000,
      UIS_DEFAULT    = 3'b001,
      UIS_ADDRESS    = 3'b010,
      UIS_CONFIGURED = 3'b011,
      UIS_SUSPENDED  = 3'b100
   } uis_dev_state_t;
   // control stage codes
   localparam logic [2:0] STG_IDLE      = 3'b000;
   localparam logic [2:0] STG_RD_DATA   = 3'b001;
   localparam logic [2:0] STG_RD_STATUS = 3'b010;
   localparam logic [2:0] STG_WR_DATA   = 3'b011;
   localparam logic [2:0] STG_WR_STATUS = 3'b100;
   localparam logic [2:0] STG_ND_STATUS = 3'b101;
   localparam logic [2:0] STG_SEQ_ERROR = 3'b110;
endpackage

//--- verilog/uis_evt_if.sv
// interface carrying usb engine events between the top and the tracker
`timescale 1ns/100ps
interface uis_evt_if;
   logic       bus_reset;    // usb bus reset detected
   logic       set_addr;     // set_address executed
   logic       addr_nonzero; // address of set_address nonzero
   logic       set_config;   // set_configuration executed
   logic       cfg_nonzero;  // configuration value nonzero
   logic       suspend;      // suspend detected
   logic       sw_reset;     // software reset
   logic [2:0] dev_state;    // tracked device state
   logic       state_event;  // tracked state changes this cycle
   modport src (output bus_reset, set_addr, addr_nonzero, set_config,
                output cfg_nonzero, suspend, sw_reset,
                input dev_state, state_event);
   modport trk (input bus_reset, set_addr, addr_nonzero, set_config,
                input cfg_nonzero, suspend, sw_reset,
                output dev_state, state_event);
endinterface

//--- verilog/uis_dev_state.sv
// device state tracker following the usb chapter-9 states
`timescale 1ns/100ps
module uis_dev_state (
   input  wire logic i_clk,
   input  wire logic i_rst,
   uis_evt_if.trk    evt
);
   uis_pkg::uis_dev_state_t state;      // current device state
   uis_pkg::uis_dev_state_t next_state; // next device state

   // next state: earlier causes in this list take precedence
   always_comb begin
      next_state = state;
      if (evt.sw_reset) begin
         next_state = uis_pkg::UIS_POWERED;
      end else if (evt.bus_reset) begin
         next_state = uis_pkg::UIS_DEFAULT;
      end else if (evt.suspend) begin
         next_state = uis_pkg::UIS_SUSPENDED;
      end else if (evt.set_addr) begin
         next_state = evt.addr_nonzero ? uis_pkg::UIS_ADDRESS
                                       : uis_pkg::UIS_DEFAULT;
      end else if (evt.set_config) begin
         next_state = evt.cfg_nonzero ? uis_pkg::UIS_CONFIGURED
                                      : uis_pkg::UIS_ADDRESS;
      end
   end

   // register the state; hardware reset gives powered
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= uis_pkg::UIS_POWERED;
      end else begin
         state <= next_state;
      end
   end

   assign evt.dev_state   = state;
   assign evt.state_event = (next_state != state); // state moves this cycle
endmodule

//--- verilog/uis_top.sv
// usb device interrupt status block with wishbone register access
`timescale 1ns/100ps
module uis_top #(
   parameter int PIPES = 7 // control pipe plus pipes 1..6
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // wishbone slave
   input  wire logic             i_wb_cyc,
   input  wire logic             i_wb_stb,
   input  wire logic             i_wb_we,
   input  wire logic [7:0]       i_wb_adr,
   input  wire logic [3:0]       i_wb_sel,
   input  wire logic [31:0]      i_wb_dat,
   output logic      [31:0]      o_wb_dat,
   output logic                  o_wb_ack,
   // usb engine events, one-cycle pulses; i_ctrl_stage is the held control stage code
   input  wire logic             i_sw_reset,
   input  wire logic             i_bus_reset,
   input  wire logic             i_set_addr,
   input  wire logic             i_addr_nonzero,
   input  wire logic             i_set_config,
   input  wire logic             i_cfg_nonzero,
   input  wire logic             i_suspend,
   input  wire logic             i_setup_done,
   input  wire logic [2:0]       i_ctrl_stage,
   input  wire logic             i_ctrl_done,
   // per-pipe status from the buffer logic; i_bus_power is the bus power level
   input  wire logic [PIPES-1:0] i_pipe_ready_set,
   input  wire logic [PIPES-1:0] i_pipe_empty_over_flags,
   input  wire logic [PIPES-1:0] i_pipe_nak_flags,
   input  wire logic             i_bus_power,
   // outputs
   output logic      [1:0]       o_pipe_response_select,
   output logic                  o_irq
);
   // ===================================================================
   // state declarations
   logic        dev_state_change_flag;      // main status b12
   logic        ctrl_stage_change_flag;     // main status b11
   logic        bus_power_change_flag;      // main status b15
   logic        setup_rcvd;                 // main status b3
   logic        bus_power_prev;             // last power sample
   logic [PIPES-1:0] ready_flags;           // pipe_ready_status
   logic [7:0]  cause_enable;               // per-cause enables
   logic [1:0]  resp_sel;                   // ctrl pipe response select
   logic        clk_on;                     // internal clock enable
   logic [2:0]  stage_prev;                 // last control stage
   logic        next_dev_state_change_flag;
   logic        next_ctrl_stage_change_flag;
   logic        next_bus_power_change_flag;
   logic        next_setup_rcvd;
   logic [PIPES-1:0] next_ready_flags;
   logic [7:0]  next_cause_enable;
   logic [1:0]  next_resp_sel;
   logic        next_clk_on;
   logic [31:0] next_rd;
   logic        next_ack;
   logic        next_irq;
   logic [15:0] main_word;                  // assembled main status
   logic        wr_en;                      // write taken this cycle
   logic        dev_cause;                  // enabled state cause
   logic        stage_cause;                // enabled stage cause

   uis_evt_if evt ();

   // ===================================================================
   // feed the device state tracker
   assign evt.bus_reset    = i_bus_reset;
   assign evt.set_addr     = i_set_addr;
   assign evt.addr_nonzero = i_addr_nonzero;
   assign evt.set_config   = i_set_config;
   assign evt.cfg_nonzero  = i_cfg_nonzero;
   assign evt.suspend      = i_suspend;
   assign evt.sw_reset     = i_sw_reset;

   uis_dev_state u_state (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .evt   (evt)
   );

   // ===================================================================
   // is this word's low byte or high byte written
   function automatic logic lane_on(input logic [3:0] sel, input int b);
      return sel[b];
   endfunction

   // ===================================================================
   // cause decoding and assembled status word
   always_comb begin
      // any enabled state cause
      dev_cause = (i_bus_reset  & cause_enable[uis_pkg::EN_BUS_RESET])
                | (i_set_addr   & cause_enable[uis_pkg::EN_SET_ADDR])
                | (i_set_config & cause_enable[uis_pkg::EN_SET_CONFIG])
                | (i_suspend    & cause_enable[uis_pkg::EN_SUSPEND]);
      // stage causes: setup complete cannot be masked
      // entry into the wr status, rd status and seq error stage codes, and ctrl done
      stage_cause = i_setup_done
         | ((i_ctrl_stage == uis_pkg::STG_WR_STATUS)
            & (stage_prev != uis_pkg::STG_WR_STATUS)
            & cause_enable[uis_pkg::EN_WR_STATUS])
         | ((i_ctrl_stage == uis_pkg::STG_RD_STATUS)
            & (stage_prev != uis_pkg::STG_RD_STATUS)
            & cause_enable[uis_pkg::EN_RD_STATUS])
         | (i_ctrl_done & cause_enable[uis_pkg::EN_CTRL_DONE])
         | ((i_ctrl_stage == uis_pkg::STG_SEQ_ERROR)
            & (stage_prev != uis_pkg::STG_SEQ_ERROR)
            & cause_enable[uis_pkg::EN_SEQ_ERROR]);
      main_word = 16'h0000;
      main_word[uis_pkg::BIT_BUS_POWER_CHG]  = bus_power_change_flag;
      main_word[uis_pkg::BIT_DEV_STATE_CHG]  = dev_state_change_flag;
      main_word[uis_pkg::BIT_CTRL_STAGE_CHG] = ctrl_stage_change_flag;
      main_word[uis_pkg::BIT_EMPTY_SUM] = |i_pipe_empty_over_flags;
      main_word[uis_pkg::BIT_NOT_READY_SUM] = |i_pipe_nak_flags;
      main_word[uis_pkg::BIT_READY_SUM] = |ready_flags;
      main_word[uis_pkg::BIT_POWER_LEVEL] = i_bus_power;
      main_word[uis_pkg::POS_DEV_STATE +: 3] = evt.dev_state;
      main_word[uis_pkg::BIT_SETUP_RCVD] = setup_rcvd;
      main_word[uis_pkg::POS_CTRL_STAGE +: 3] = i_ctrl_stage;
   end

   // ===================================================================
   // register next values, bus access and flag set/clear
   always_comb begin
      wr_en = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
      next_ack = i_wb_cyc & i_wb_stb & ~o_wb_ack;
      next_dev_state_change_flag  = dev_state_change_flag;
      next_ctrl_stage_change_flag = ctrl_stage_change_flag;
      next_bus_power_change_flag  = bus_power_change_flag;
      next_setup_rcvd   = setup_rcvd;
      next_ready_flags  = ready_flags;
      next_cause_enable = cause_enable;
      next_resp_sel     = resp_sel;
      next_clk_on       = clk_on;
      next_rd           = 32'h0000_0000;
      // clears by written zero, only with the clock running
      if (wr_en && clk_on && i_wb_adr == uis_pkg::MAIN_STATUS_OFS) begin
         if (lane_on(i_wb_sel, 1)) begin
            if (!i_wb_dat[uis_pkg::BIT_DEV_STATE_CHG])
               next_dev_state_change_flag = 1'b0;
            if (!i_wb_dat[uis_pkg::BIT_CTRL_STAGE_CHG])
               next_ctrl_stage_change_flag = 1'b0;
            if (!i_wb_dat[uis_pkg::BIT_BUS_POWER_CHG])
               next_bus_power_change_flag = 1'b0;
         end
         if (lane_on(i_wb_sel, 0) && !i_wb_dat[uis_pkg::BIT_SETUP_RCVD])
            next_setup_rcvd = 1'b0;
      end
      // ready bits clear on zero, ignore one
      if (wr_en && clk_on && i_wb_adr == uis_pkg::READY_STATUS_OFS
          && lane_on(i_wb_sel, 0)) begin
         next_ready_flags = ready_flags & i_wb_dat[PIPES-1:0];
      end
      if (wr_en && i_wb_adr == uis_pkg::ENABLE_OFS && lane_on(i_wb_sel, 0))
         next_cause_enable = i_wb_dat[7:0];
      if (wr_en && i_wb_adr == uis_pkg::CLK_CTRL_OFS && lane_on(i_wb_sel, 0))
         next_clk_on = i_wb_dat[0];
      // response select locked while setup flag is set
      if (wr_en && i_wb_adr == uis_pkg::RESP_SEL_OFS
          && lane_on(i_wb_sel, 0) && !setup_rcvd)
         next_resp_sel = i_wb_dat[1:0];
      // hardware sets win over clears
      if (dev_cause) next_dev_state_change_flag = 1'b1;
      if (stage_cause) next_ctrl_stage_change_flag = 1'b1;
      if (i_bus_power != bus_power_prev)
         next_bus_power_change_flag = 1'b1;
      if (i_setup_done) next_setup_rcvd = 1'b1;
      next_ready_flags = next_ready_flags | i_pipe_ready_set;
      // read mux; unmapped reads as zero with ack
      unique case (i_wb_adr)
         uis_pkg::MAIN_STATUS_OFS:  next_rd[15:0] = main_word;
         uis_pkg::READY_STATUS_OFS: next_rd[PIPES-1:0] = ready_flags;
         uis_pkg::ENABLE_OFS:       next_rd[7:0] = cause_enable;
         uis_pkg::RESP_SEL_OFS:     next_rd[1:0] = resp_sel;
         uis_pkg::CLK_CTRL_OFS:     next_rd[0] = clk_on;
         default:                   next_rd = 32'h0000_0000;
      endcase
      // interrupt: setup flag alone raises none
      next_irq = next_dev_state_change_flag | next_ctrl_stage_change_flag
               | next_bus_power_change_flag | (|i_pipe_empty_over_flags)
               | (|i_pipe_nak_flags) | (|next_ready_flags);
   end

   // ===================================================================
   // registers; ready register ignores usb bus reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         dev_state_change_flag  <= 1'b0;
         ctrl_stage_change_flag <= 1'b0;
         bus_power_change_flag  <= 1'b0;
         setup_rcvd   <= 1'b0;
         bus_power_prev <= 1'b0;
         ready_flags  <= uis_pkg::READY_RESET[PIPES-1:0];
         cause_enable <= uis_pkg::ENABLE_RESET;
         resp_sel     <= uis_pkg::RESP_RESET;
         clk_on       <= 1'b1;
         stage_prev   <= uis_pkg::STG_IDLE;
         o_wb_dat     <= 32'h0000_0000;
         o_wb_ack     <= 1'b0;
         o_irq        <= 1'b0;
         o_pipe_response_select <= uis_pkg::RESP_RESET;
      end else begin
         dev_state_change_flag  <= next_dev_state_change_flag;
         ctrl_stage_change_flag <= next_ctrl_stage_change_flag;
         bus_power_change_flag  <= next_bus_power_change_flag;
         setup_rcvd   <= next_setup_rcvd;
         bus_power_prev <= i_bus_power;
         ready_flags  <= i_sw_reset ? uis_pkg::READY_RESET[PIPES-1:0]
                                    : next_ready_flags;
         cause_enable <= next_cause_enable;
         resp_sel     <= next_resp_sel;
         clk_on       <= next_clk_on;
         stage_prev   <= i_ctrl_stage;
         o_wb_dat     <= next_rd;
         o_wb_ack     <= next_ack;
         o_irq        <= next_irq;
         o_pipe_response_select <= next_resp_sel;
      end
   end
endmodule

//--- verif/uis_top_asserts.sv
// port-level checks for the usb interrupt status block
`timescale 1ns/100ps
module uis_top_asserts #(
   parameter int PIPES = 7 // control pipe plus pipes 1..6
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_wb_cyc,
   input  wire logic             i_wb_stb,
   input  wire logic             i_wb_we,
   input  wire logic [7:0]       i_wb_adr,
   input  wire logic [31:0]      o_wb_dat,
   input  wire logic             o_wb_ack,
   input  wire logic             i_setup_done,
   input  wire logic [PIPES-1:0] i_pipe_ready_set,
   input  wire logic [PIPES-1:0] i_pipe_nak_flags,
   input  wire logic             i_bus_power,
   input  wire logic             o_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==================================================================
   // bus handshake
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   ack_take_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("request not answered in one cycle");
   ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without a request");
   unmapped_zero_a: assert property (o_wb_ack && $past(!i_wb_we
      && i_wb_adr == 8'h10) |-> o_wb_dat == 32'h0000_0000)
      else $error("unmapped read not zero");
   // ==================================================================
   // status causes reach the request line; ready read upper bits and outputs after reset
   setup_irq_a:
      assert property (i_setup_done |-> ##[1:2] o_irq)
      else $error("setup completion raised no request");
   ready_irq_a:
      assert property (|i_pipe_ready_set |-> ##[1:2] o_irq)
      else $error("pipe ready raised no request");
   nak_irq_a:
      assert property ((|i_pipe_nak_flags) [*3] |-> o_irq)
      else $error("nak summary raised no request");
   power_irq_a:
      assert property ($changed(i_bus_power) && !$past(i_rst) |-> ##[1:3] o_irq)
      else $error("power change raised no request");
   ready_upper_a:
      assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr ==
         uis_pkg::READY_STATUS_OFS) |-> o_wb_dat[31:7] == 25'h000_0000)
      else $error("ready register upper bits not zero");
   reset_quiet_a:
      assert property ($past(i_rst) |-> !o_irq && !o_wb_ack)
      else $error("outputs active after reset");
endmodule

//--- verif/uis_host_model.sv
// wishbone master standing in for host software
`timescale 1ns/100ps
module uis_host_model (
   input  wire logic        i_clk,
   input  wire logic        i_ack,
   input  wire logic [31:0] i_dat,
   output logic             o_cyc,
   output logic             o_stb,
   output logic             o_we,
   output logic [7:0]       o_adr,
   output logic [3:0]       o_sel,
   output logic [31:0]      o_dat
);
   initial begin
      {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
   end
   // one classic cycle, entered just after a rising edge
   task automatic xfer(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, we, a, 4'hF, d};
      // wait for the answer; only the bench watchdog ends a hang
      do begin
         @(posedge i_clk);
      end while (!i_ack);
      q = i_dat;
      // released address and data lines show no stale value
      {o_cyc, o_stb, o_adr, o_dat} <= {2'b00, ~a, ~d};
      repeat (13) @(posedge i_clk); // clears spaced over 100 ns
   endtask
endmodule

//--- verif/uis_top_tb.sv
// self-checking bench for the usb interrupt status block
`timescale 1ns/100ps
module uis_top_tb;
   localparam logic [7:0]  MS  = uis_pkg::MAIN_STATUS_OFS;
   localparam logic [7:0]  RS  = uis_pkg::READY_STATUS_OFS;
   localparam logic [7:0]  ES  = uis_pkg::ENABLE_OFS;
   localparam logic [7:0]  PS  = uis_pkg::RESP_SEL_OFS;
   localparam logic [7:0]  CS  = uis_pkg::CLK_CTRL_OFS;
   localparam logic [31:0] M16 = 32'h0000_FFFF;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic        i_clk, i_rst, cyc, stb, we, ack, irq, pwr, nz;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [6:0]  ev, rdy_set, emp, nak;
   logic [2:0]  stg;
   logic [1:0]  rsel;
   int          n_errors, tests_run, m_pc, m_dv, m_ct, m_su, m_st, m_rdy, r;
   int          evb[7] = '{1, 2, 3, 3, 2, 4, 1}; // event bit per step
   int          evz[7] = '{0, 1, 1, 0, 0, 0, 0}; // nonzero qualifier
   int          evs[7] = '{1, 2, 3, 2, 1, 4, 1}; // state after step
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   uis_top uis_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sw_reset(ev[0]),
      .i_bus_reset(ev[1]), .i_set_addr(ev[2]), .i_addr_nonzero(nz),
      .i_set_config(ev[3]), .i_cfg_nonzero(nz), .i_suspend(ev[4]),
      .i_setup_done(ev[5]), .i_ctrl_stage(stg), .i_ctrl_done(ev[6]),
      .i_pipe_ready_set(rdy_set), .i_pipe_empty_over_flags(emp),
      .i_pipe_nak_flags(nak), .i_bus_power(pwr),
      .o_pipe_response_select(rsel), .o_irq(irq));
   uis_host_model uis_host_model_i (.i_clk(i_clk), .i_ack(ack),
      .i_dat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr),
      .o_sel(sel), .o_dat(wdat));
   // ==================================================================
   // reference model of the main status word
   function automatic logic [31:0] exp_main();
      return {16'h0000, m_pc[0], 2'b00, m_dv[0], m_ct[0], |emp, |nak,
              m_rdy != 0, pwr, m_st[2:0], m_su[0], stg};
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      uis_host_model_i.xfer(1'b0, a, 32'h0000_0000, q);
      cmp(q & m, e & m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      uis_host_model_i.xfer(1'b1, a, d, q);
   endtask
   // one-cycle engine event, set pulses dropped with it
   task automatic pulse(input int b, input logic z);
      ev[b] <= 1'b1;
      nz <= z;
      @(posedge i_clk);
      ev <= '0;
      rdy_set <= '0;
      @(posedge i_clk);
   endtask
   // clear every main status flag in one write
   task automatic clr_all();
      wr(MS, 32'h0000_0000);
      {m_pc, m_dv, m_ct, m_su} = '0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      report_and_stop();
   end
   // ==================================================================
   // main sequence
   initial begin
      i_rst = 1'b1;
      {nz, ev, rdy_set, emp, nak, stg, pwr} = '0;
      void'($urandom(68));
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(MS, exp_main(), M16);
      rd(RS, 32'h0000_0000, ALL);
      rd(8'h10, 32'h0000_0000, ALL);
      for (int k = 0; k < 6; k++) begin
         r = $urandom;
         rdy_set <= r[6:0];
         @(posedge i_clk);
         rdy_set <= '0;
         m_rdy |= r & 32'h0000_007F;
         rd(RS, m_rdy, ALL);
         rd(MS, exp_main(), M16);
         r = $urandom;
         wr(RS, r);
         m_rdy &= r;
         rd(RS, m_rdy, ALL);
      end
      for (int k = 0; k < 7; k++) begin
         pulse(evb[k], evz[k][0]);
         m_st = evs[k];
         m_dv = 1;
         rd(MS, exp_main(), M16);
         clr_all();
      end
      rd(RS, m_rdy, ALL);
      wr(ES, 32'h0000_00FE);
      pulse(1, 1'b0);
      rd(MS, exp_main(), M16);
      wr(ES, 32'h0000_00FF);
      pulse(2, 1'b1);
      pulse(0, 1'b0);
      {m_st, m_rdy} = '0;
      rd(MS, exp_main(), 32'h0000_0170);
      rd(RS, 32'h0000_0000, ALL);
      clr_all();
      rdy_set <= 7'h7F;
      pulse(5, 1'b0);
      {m_rdy, m_su, m_ct} = {32'h0000_007F, 32'h0000_0001, 32'h0000_0001};
      rd(MS, exp_main(), M16);
      wr(PS, 32'h0000_0003);
      cmp(32'(rsel), 32'h0000_0000);
      wr(CS, 32'h0000_0000);
      wr(MS, 32'h0000_0000);
      wr(RS, 32'h0000_0000);
      rd(MS, exp_main(), M16);
      rd(RS, m_rdy, ALL);
      wr(CS, 32'h0000_0001);
      wr(RS, 32'h0000_0000);
      wr(MS, 32'h0000_F7FF);
      {m_rdy, m_ct} = '0;
      rd(MS, exp_main(), M16);
      cmp(32'(irq), 32'h0000_0000);
      wr(MS, 32'h0000_FFF7);
      m_su = 0;
      wr(PS, 32'h0000_0003);
      cmp(32'(rsel), 32'h0000_0003);
      for (int c = 0; c < 7; c++) begin
         stg <= 3'(c);
         @(posedge i_clk);
         if (c == 2 || c == 4 || c == 6) m_ct = 1;
         rd(MS, exp_main(), M16);
      end
      stg <= 3'h0;
      clr_all();
      wr(ES, 32'h0000_007F);
      stg <= 3'h6;
      @(posedge i_clk);
      rd(MS, exp_main(), M16);
      pulse(6, 1'b0);
      m_ct = 1;
      rd(MS, exp_main(), M16);
      wr(ES, 32'h0000_00FF);
      clr_all();
      r = $urandom;
      emp <= 7'(r) | 7'h01;
      nak <= 7'(r >> 8) | 7'h40;
      pwr <= 1'b1;
      m_pc = 1;
      @(posedge i_clk);
      repeat (3) rd(MS, exp_main(), M16);
      cmp(32'(irq), 32'h0000_0001);
      emp <= '0;
      nak <= '0;
      @(posedge i_clk);
      clr_all();
      rd(MS, exp_main(), M16);
      cmp(32'(irq), 32'h0000_0000);
      report_and_stop();
   end
endmodule
bind uis_top uis_top_asserts #(.PIPES(PIPES)) uis_top_asserts_i (.*);
